// file: logic/awd_defines.svh
/*
 * Constants of the autonomous watchdog control block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef AWD_DEFINES_SVH
`define AWD_DEFINES_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses on APB; AWD_CTRL_INDEX is the control register's word index)
// ----------------------------------------------------------------------
`define AWD_CTRL_INDEX 8'h0A
`define AWD_CTRL_ADDR 12'h028
`define AWD_IRQ_STAT_ADDR 12'h100
`define AWD_IRQ_MASK_ADDR 12'h104
`define AWD_MODE_ADDR 12'h108

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define AWD_BIT_RESTART 5
`define AWD_BIT_RST_EN 4
`define AWD_BIT_IRQ_EN 3
`define AWD_BIT_CC_EN 2
`define AWD_BIT_FLAG 1
`define AWD_BIT_RATE 0
`define AWD_CTRL_RESET 8'h00

// ----------------------------------------------------------------------
// Event status bits
// ----------------------------------------------------------------------
`define AWD_EV_TIMEOUT 0
`define AWD_EV_SYS_RESET 1
`define AWD_EV_WAKE 2
`define AWD_EV_HALL 3
`define AWD_EV_W 4

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define AWD_CLK_MHZ 125
`define AWD_FAST_MS 10
`define AWD_SLOW_MS 20
`define AWD_FAST_CYCLES (`AWD_FAST_MS * 1000 * `AWD_CLK_MHZ)
`define AWD_SLOW_CYCLES (`AWD_SLOW_MS * 1000 * `AWD_CLK_MHZ)
`define AWD_RST_PULSE 16
`define AWD_CC_SETTLE 4

`endif

// file: logic/awd_pkg.sv
/*
 * Types shared by the autonomous watchdog control block.
 * Assumes awd_defines.svh supplies the numbers.
 */
`default_nettype none

package awd_pkg;
    typedef struct packed {
        logic rate;
        logic flag;
        logic cc_en;
        logic irq_en;
        logic rst_en;
    } awd_ctrl_t;

    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } awd_apb_req_t;

    typedef enum logic [1:0] {
        AWD_CC_IDLE = 2'b00,
        AWD_CC_POWER = 2'b01,
        AWD_CC_SAMPLE = 2'b10
    } awd_cc_state_t;
endpackage : awd_pkg

`default_nettype wire

// file: logic/awd_timer.sv
/*
 * Timeout counter of the autonomous watchdog.
 * Assumes one clock and a synchronous active-high reset.
 */
`include "awd_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module awd_timer #(
    parameter int FAST_CYCLES = `AWD_FAST_CYCLES,
    parameter int SLOW_CYCLES = `AWD_SLOW_CYCLES
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic run_in,
    input wire logic restart_in,
    input wire logic fast_in,
    output logic expire_out
);
    typedef struct packed {
        logic [31:0] count;
        logic expire;
    } awd_tmr_state_t;

    awd_tmr_state_t st;
    awd_tmr_state_t next_st;
    logic [31:0] limit;

    always_comb begin
        limit = fast_in ? 32'(FAST_CYCLES - 1) : 32'(SLOW_CYCLES - 1);
        next_st = st;
        next_st.expire = 1'b0;
        if (restart_in) begin
            next_st.count = 32'h0000_0000;
        end else if (run_in) begin
            if (st.count >= limit) begin
                next_st.count = 32'h0000_0000;
                next_st.expire = 1'b1;
            end else begin
                next_st.count = st.count + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign expire_out = st.expire;

    count_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !run_in && !restart_in |=> st.count == $past(st.count))
        else $error("counter moved while stopped");
endmodule : awd_timer

`default_nettype wire

// file: logic/awd_ctrl.sv
/*
 * Autonomous watchdog control: control register over APB, timeout reset in
 * RUN mode, wake interrupt in STOP mode, cyclic Hall sensor check.
 * Assumes stop_mode_in comes from the system power controller, synchronous.
 */
// Summary of operation
// - Writing one to restart bit clears counter; bit reads zero.
// - Timeout with reset enable drives low system reset, RUN only.
// - Reset enable sets once; further writes ignored until reset.
// - Flag with interrupt enable drives low interrupt, STOP only.
// - Cyclic check bit turns periodic sensor checking on or off.
// - Hardware sets timeout flag; writing one clears, zero no effect.
// - Clearing the flag also restarts the timeout period.
// - Rate bit one picks 10 ms, zero picks 20 ms.
// - Reset clears the register; bits 7 and 6 read zero.
// - Counter runs only while any of three enables is set.
// - Reset watchdog pauses in STOP and resumes in RUN.
// - In STOP with interrupt enable, wake after each period.
// - Cyclic check powers, samples Hall inputs; a one wakes system.
`include "awd_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module awd_ctrl #(
    parameter int FAST_CYCLES = `AWD_FAST_CYCLES,
    parameter int SLOW_CYCLES = `AWD_SLOW_CYCLES,
    parameter int HALL_W = 3
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic [11:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic stop_mode_in,
    input wire logic [HALL_W-1:0] hall_in,
    input wire logic hall_irq_en_in,
    output logic sys_rst_n_out,
    output logic irq_n_out,
    output logic [HALL_W-1:0] hall_power_out,
    output logic analog_check_out,
    output logic irq_out
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        awd_pkg::awd_ctrl_t ctrl;
        logic [`AWD_EV_W-1:0] status;
        logic [`AWD_EV_W-1:0] mask;
        logic [HALL_W-1:0] hall_sel;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [4:0] rst_cnt;
        logic sys_rst_n;
        logic irq_n;
        logic hall_wake;
        awd_pkg::awd_cc_state_t cc_state;
        logic [2:0] cc_cnt;
        logic [HALL_W-1:0] hall_power;
        logic analog_check;
        logic irq;
    } awd_state_t;

    awd_state_t st;
    awd_state_t next_st;
    awd_pkg::awd_apb_req_t req;
    logic expire;
    logic restart;
    logic run_cnt;
    logic wr_ctrl;
    logic acc_take;

    // A write counts only on the edge at which the master sees pready, so the
    // first access cycle can neither clear the flag nor restart the counter
    function automatic logic apb_write(input awd_pkg::awd_apb_req_t r, input logic take, input logic [11:0] a);
        apb_write = take && r.psel && r.penable && r.pwrite && (r.paddr == a);
    endfunction : apb_write

    assign req = '{paddr: paddr_in, psel: psel_in, penable: penable_in,
                   pwrite: pwrite_in, pwdata: pwdata_in};
    assign acc_take = psel_in && penable_in && st.pready;
    assign wr_ctrl = apb_write(req, acc_take, `AWD_CTRL_ADDR);

    // Restart on command or flag clear; both hit the same counter reset
    assign restart = wr_ctrl && (pwdata_in[`AWD_BIT_RESTART]
        || (pwdata_in[`AWD_BIT_FLAG] && st.ctrl.flag));

    // The reset-only function freezes in STOP; interrupt and cyclic
    // check keep the oscillator running there
    assign run_cnt = (st.ctrl.irq_en || st.ctrl.cc_en || st.ctrl.rst_en)
        && !(stop_mode_in && !st.ctrl.irq_en && !st.ctrl.cc_en);

    awd_timer #(
        .FAST_CYCLES(FAST_CYCLES),
        .SLOW_CYCLES(SLOW_CYCLES)
    ) u_timer (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .run_in(run_cnt),
        .restart_in(restart),
        .fast_in(st.ctrl.rate),
        .expire_out(expire)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [`AWD_EV_W-1:0] ev;
        logic [`AWD_EV_W-1:0] clr;
        ev = '0;
        clr = '0;
        next_st = st;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;

        // Register writes
        if (wr_ctrl) begin
            if (!st.ctrl.rst_en) begin
                next_st.ctrl.rst_en = pwdata_in[`AWD_BIT_RST_EN];
            end
            next_st.ctrl.irq_en = pwdata_in[`AWD_BIT_IRQ_EN];
            next_st.ctrl.cc_en = pwdata_in[`AWD_BIT_CC_EN];
            next_st.ctrl.rate = pwdata_in[`AWD_BIT_RATE];
            if (pwdata_in[`AWD_BIT_FLAG]) begin
                next_st.ctrl.flag = 1'b0;
            end
        end
        if (apb_write(req, acc_take, `AWD_IRQ_MASK_ADDR)) begin
            next_st.mask = pwdata_in[`AWD_EV_W-1:0];
        end
        if (apb_write(req, acc_take, `AWD_MODE_ADDR)) begin
            next_st.hall_sel = pwdata_in[HALL_W-1:0];
        end
        if (apb_write(req, acc_take, `AWD_IRQ_STAT_ADDR)) begin
            clr = pwdata_in[`AWD_EV_W-1:0];
        end

        // Timeout: flag set wins over a same-cycle clear
        if (expire) begin
            next_st.ctrl.flag = 1'b1;
            ev[`AWD_EV_TIMEOUT] = 1'b1;
            if (st.ctrl.rst_en && !stop_mode_in) begin
                next_st.rst_cnt = 5'(`AWD_RST_PULSE);
                ev[`AWD_EV_SYS_RESET] = 1'b1;
            end
        end

        // Reset pulse stretcher
        if (st.rst_cnt != 5'h00) begin
            next_st.rst_cnt = st.rst_cnt - 5'h01;
        end
        next_st.sys_rst_n = (next_st.rst_cnt == 5'h00);

        // Cyclic check sequencer: in STOP mode, power sensors each period, then sample
        next_st.hall_wake = 1'b0;
        unique case (st.cc_state)
            awd_pkg::AWD_CC_IDLE: begin
                if (expire && st.ctrl.cc_en && stop_mode_in) begin
                    next_st.cc_state = awd_pkg::AWD_CC_POWER;
                    next_st.cc_cnt = 3'(`AWD_CC_SETTLE);
                end
            end
            awd_pkg::AWD_CC_POWER: begin
                if (!st.ctrl.cc_en) begin
                    next_st.cc_state = awd_pkg::AWD_CC_IDLE;
                end else if (st.cc_cnt == 3'h0) begin
                    next_st.cc_state = awd_pkg::AWD_CC_SAMPLE;
                end else begin
                    next_st.cc_cnt = st.cc_cnt - 3'h1;
                end
            end
            awd_pkg::AWD_CC_SAMPLE: begin
                next_st.cc_state = awd_pkg::AWD_CC_IDLE;
                if (hall_irq_en_in && |(hall_in & st.hall_sel)) begin
                    next_st.hall_wake = 1'b1;
                    ev[`AWD_EV_HALL] = 1'b1;
                end
            end
            default: begin
                next_st.cc_state = awd_pkg::AWD_CC_IDLE;
            end
        endcase
        next_st.hall_power = (next_st.cc_state != awd_pkg::AWD_CC_IDLE) ? st.hall_sel : '0;
        next_st.analog_check = (next_st.cc_state != awd_pkg::AWD_CC_IDLE);

        // Wake line: flag with interrupt enable in STOP mode, or a Hall wake from the sample step
        next_st.irq_n = !((next_st.ctrl.flag && st.ctrl.irq_en && stop_mode_in)
            || next_st.hall_wake);
        if (!next_st.irq_n && st.irq_n) begin
            ev[`AWD_EV_WAKE] = 1'b1;
        end

        next_st.status = (st.status & ~clr) | ev;
        next_st.irq = |(next_st.status & next_st.mask);

        // APB answer in the access phase, after one wait state
        if (psel_in && penable_in && !st.pready) begin
            next_st.pready = 1'b1;
            next_st.prdata = 32'h0000_0000;
            unique case (paddr_in)
                `AWD_CTRL_ADDR: begin
                    next_st.prdata[`AWD_BIT_RST_EN] = st.ctrl.rst_en;
                    next_st.prdata[`AWD_BIT_IRQ_EN] = st.ctrl.irq_en;
                    next_st.prdata[`AWD_BIT_CC_EN] = st.ctrl.cc_en;
                    next_st.prdata[`AWD_BIT_FLAG] = st.ctrl.flag;
                    next_st.prdata[`AWD_BIT_RATE] = st.ctrl.rate;
                end
                `AWD_IRQ_STAT_ADDR: next_st.prdata[`AWD_EV_W-1:0] = st.status;
                `AWD_IRQ_MASK_ADDR: next_st.prdata[`AWD_EV_W-1:0] = st.mask;
                `AWD_MODE_ADDR: next_st.prdata[HALL_W-1:0] = st.hall_sel;
                default: next_st.pslverr = 1'b1;
            endcase
        end
    end

    // Writes are already gated to the cycle with pready high
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            st <= '0;
            st.sys_rst_n <= 1'b1;
            st.irq_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign prdata_out = st.prdata;
    assign pready_out = st.pready;
    assign pslverr_out = st.pslverr;
    assign sys_rst_n_out = st.sys_rst_n;
    assign irq_n_out = st.irq_n;
    assign hall_power_out = st.hall_power;
    assign analog_check_out = st.analog_check;
    assign irq_out = st.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    reset_once_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        st.ctrl.rst_en |=> st.ctrl.rst_en)
        else $error("reset enable cleared by software");
    reset_run_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        expire && st.ctrl.rst_en && !stop_mode_in |=> !sys_rst_n_out[*8])
        else $error("timeout reset not asserted");
    reset_stop_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        expire && stop_mode_in && st.rst_cnt == 5'h00 |=> sys_rst_n_out)
        else $error("reset asserted in stop mode");
    irq_stop_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !irq_n_out && !st.hall_wake |-> $past(stop_mode_in))
        else $error("wake line low outside stop mode");
    flag_set_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        expire |=> st.ctrl.flag)
        else $error("flag not set on expiry");
    flag_zero_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        st.ctrl.flag && !wr_ctrl |=> st.ctrl.flag)
        else $error("flag lost without clear");
    bits_zero_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        pready_out && $past(paddr_in) == `AWD_CTRL_ADDR |-> prdata_out[7:5] == 3'h0)
        else $error("reserved control bits read nonzero");
    stopped_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !st.ctrl.rst_en && !st.ctrl.irq_en && !st.ctrl.cc_en |=> !expire)
        else $error("timer expired while disabled");
    cc_off_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !st.ctrl.cc_en && st.cc_state == awd_pkg::AWD_CC_IDLE |=> !analog_check_out)
        else $error("cyclic check ran while disabled");
    restart_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        restart |=> !expire[*8])
        else $error("no fresh period after restart");
    flag_clear_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        wr_ctrl && pwdata_in[`AWD_BIT_FLAG] && !expire |=> !st.ctrl.flag)
        else $error("flag not cleared by write of one");
    wake_stop_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        st.ctrl.flag && st.ctrl.irq_en && stop_mode_in && !wr_ctrl |=> !irq_n_out)
        else $error("no wake on flag in stop mode");
    reset_pulse_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        $fell(sys_rst_n_out) |-> st.rst_cnt == 5'(`AWD_RST_PULSE))
        else $error("reset pulse not full length");
    reset_idle_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !st.ctrl.rst_en && st.rst_cnt == 5'h00 |=> sys_rst_n_out)
        else $error("reset asserted while disabled");
    cc_start_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        expire && st.ctrl.cc_en && stop_mode_in && st.cc_state == awd_pkg::AWD_CC_IDLE
        |=> analog_check_out)
        else $error("cyclic check did not start");
    hall_wake_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        st.hall_wake |-> $past(st.cc_state == awd_pkg::AWD_CC_SAMPLE))
        else $error("hall wake outside sample step");
    ready_wait_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        psel_in && penable_in && !pready_out |=> pready_out)
        else $error("access phase not answered");
    ready_pulse_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        pready_out |=> !pready_out && !pslverr_out)
        else $error("ready held longer than one cycle");
    irq_level_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        irq_out == |(st.status & st.mask))
        else $error("interrupt level does not follow status");
endmodule : awd_ctrl

`default_nettype wire

// file: dv/awd_mcu_model.sv
/*
 * Behavioural model of the embedded core that faces the watchdog: its
 * RUN/STOP state and counters of reset pulses and wake-ups.
 * Assumes the watchdog's clock and synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none

module awd_mcu_model (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic sys_rst_n_in,
    input wire logic irq_n_in,
    input wire logic stop_req_in,
    input wire logic run_req_in,
    output logic stop_mode_out,
    output logic [15:0] resets_out,
    output logic [15:0] wakes_out,
    output logic [15:0] pulse_len_out
);
    logic [15:0] low_cnt;

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            {stop_mode_out, resets_out, wakes_out, pulse_len_out, low_cnt} <= '0;
        end else begin
            if (!sys_rst_n_in) begin
                low_cnt <= low_cnt + 16'h0001;
            end else if (low_cnt != 16'h0000) begin
                pulse_len_out <= low_cnt;
                resets_out <= resets_out + 16'h0001;
                low_cnt <= 16'h0000;
            end
            // A reset always leaves the core in RUN, whatever was requested
            if (!sys_rst_n_in || run_req_in) begin
                stop_mode_out <= 1'b0;
            end else if (stop_mode_out && !irq_n_in) begin
                stop_mode_out <= 1'b0;
                wakes_out <= wakes_out + 16'h0001;
            end else if (stop_req_in) begin
                stop_mode_out <= 1'b1;
            end
        end
    end
endmodule : awd_mcu_model

`default_nettype wire

// file: dv/autonomous_watchdog_ctrl_test.sv
/*
 * Self-checking bench of the watchdog control block with a core model.
 * Assumes the short sim periods of 50 and 100 cycles.
 */
`include "awd_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module autonomous_watchdog_ctrl_test;
    localparam logic [11:0] CTRL = `AWD_CTRL_ADDR;
    localparam logic [11:0] STAT = `AWD_IRQ_STAT_ADDR;
    localparam logic [11:0] MASK = `AWD_IRQ_MASK_ADDR;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    awd_pkg::awd_apb_req_t req = '0;
    logic stop_req = 1'b0;
    logic run_req = 1'b0;
    logic [2:0] hall = 3'h0;
    logic hall_en = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, stop_mode, rst_n, irq_n, chk, irq;
    logic [2:0] hpow;
    logic [2:0] pow_seen = 3'h0;
    logic [15:0] resets, wakes, plen, b;
    logic [33:0] exp_q[$];
    logic [33:0] nxt;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    int cc_cnt = 0;
    int i;

    awd_ctrl #(.FAST_CYCLES(50), .SLOW_CYCLES(100), .HALL_W(3)) i_awd_ctrl (.mclk_in(mclk),
        .sys_rst_in(sys_rst), .paddr_in(req.paddr), .psel_in(req.psel), .penable_in(req.penable),
        .pwrite_in(req.pwrite), .pwdata_in(req.pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .stop_mode_in(stop_mode), .hall_in(hall), .hall_irq_en_in(hall_en),
        .sys_rst_n_out(rst_n), .irq_n_out(irq_n), .hall_power_out(hpow), .analog_check_out(chk),
        .irq_out(irq));
    awd_mcu_model i_awd_mcu_model (.mclk_in(mclk), .sys_rst_in(sys_rst), .sys_rst_n_in(rst_n),
        .irq_n_in(irq_n), .stop_req_in(stop_req), .run_req_in(run_req), .stop_mode_out(stop_mode),
        .resets_out(resets), .wakes_out(wakes), .pulse_len_out(plen));

    initial begin
        forever #4 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task final_report;
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report

    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Request held until pready is sampled high; the note goes in first
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        exp_q.push_back({~w, e});
        @(posedge mclk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge mclk);
        req.penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr

    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask : rd

    task go(input logic s);
        @(posedge mclk);
        stop_req <= s;
        run_req <= ~s;
        @(posedge mclk);
        stop_req <= 1'b0;
        run_req <= 1'b0;
    endtask : go

    task automatic wait_chg(ref logic [15:0] v, input int n);
        b = v;
        for (i = 0; i < n && v == b; i++) @(posedge mclk);
    endtask : wait_chg

    // ------------------------------------------------------------
    // Watchers
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (req.psel && req.penable && pready === 1'b1) begin
            nxt = exp_q.pop_front();
            check({31'h0, pslverr}, {31'h0, nxt[32]});
            if (nxt[33]) check(prdata, nxt[31:0]);
        end
        if (chk === 1'b1) begin
            cc_cnt++;
            pow_seen = hpow;
        end
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("BAD %0t: run did not finish", $time);
            final_report();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        i = $urandom(32'hA0E5FA1A);
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(CTRL, 32'h0);
        apb(1'b0, 12'h0FC, 32'h0, 33'h100000000);
        wr(MASK, 32'h1);
        wr(CTRL, ($urandom() & 32'hFFFFFF00) | 32'h000000C9);
        repeat (60) @(posedge mclk);
        check(irq_n, 1'b1);
        rd(CTRL, 32'h0B);
        check(irq, 1'b1);
        rd(STAT, 32'h1);
        wr(MASK, 32'h0);
        repeat (2) @(posedge mclk);
        check(irq, 1'b0);
        wr(STAT, 32'h1);
        rd(STAT, 32'h0);
        wr(MASK, 32'h1);
        wr(CTRL, 32'h09);
        rd(CTRL, 32'h0B);
        wr(CTRL, 32'h0B);
        repeat (36) @(posedge mclk);
        rd(CTRL, 32'h09);
        repeat (15) @(posedge mclk);
        rd(CTRL, 32'h0B);
        wr(CTRL, 32'h0A);
        repeat (70) @(posedge mclk);
        rd(CTRL, 32'h08);
        repeat (35) @(posedge mclk);
        rd(CTRL, 32'h0A);
        wr(CTRL, 32'h0B);
        go(1'b1);
        wait_chg(wakes, 70);
        check(wakes, b + 16'h1);
        wr(CTRL, 32'h05);
        wr(MASK + 12'h004, 32'h1);
        hall <= 3'h1 | 3'($urandom() & 32'h6);
        hall_en <= 1'b1;
        go(1'b1);
        wait_chg(wakes, 130);
        check(wakes, b + 16'h1);
        check(pow_seen, 3'h1);
        wr(CTRL, 32'h02);
        go(1'b1);
        i = cc_cnt;
        repeat (200) @(posedge mclk);
        check(cc_cnt, i);
        go(1'b0);
        rd(CTRL, 32'h0);
        wr(CTRL, 32'h11);
        wr(CTRL, 32'h01);
        rd(CTRL, 32'h11);
        b = resets;
        // Restart well inside each period so no reset may follow
        repeat (6) begin
            repeat (20) @(posedge mclk);
            wr(CTRL, 32'h31);
        end
        rd(CTRL, 32'h11);
        check(resets, b);
        wait_chg(resets, 90);
        check(resets, b + 16'h1);
        check(plen, `AWD_RST_PULSE);
        wr(CTRL, 32'h13);
        go(1'b1);
        b = resets;
        repeat (200) @(posedge mclk);
        check(resets, b);
        go(1'b0);
        wait_chg(resets, 90);
        check(resets, b + 16'h1);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(CTRL, 32'h0);
        wr(CTRL, 32'h10);
        rd(CTRL, 32'h10);
        repeat (4) @(posedge mclk);
        final_report();
    end
endmodule : autonomous_watchdog_ctrl_test

`default_nettype wire
